// ---- design/ring_fieldbus_slave_gateway.sv ----
// gateway mirroring process words between ethercat side and ring fieldbus slave port
`timescale 1ns/1ns
//==========================================================
// ring fieldbus slave gateway
//==========================================================
// Contract
// - every process item is one 16-bit word
// - at most 32 words each direction
// - no words configured: stay in SAFE-OP
// - configured and reloaded: reach OP, present in count mod 16, out count mod 8
// - INIT resets and holds protocol chip
// - not OP: station error, inputs invalid
// - watchdog expiry raises station error
// - status 0x2000 on station error
// - status 0x4000 on invalid ring data
// - baud object selects 2 Mbit or 500k
// - stored ring config mismatch aborts with 0x0026
// - output words reach ring in order
// - both directions mirrored with minimum delay
// - identification register read in id cycle
// - ring data shifts serially, both directions
module ring_fieldbus_slave_gateway
    import ring_gw_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [1:0] ecat_state,
    input wire logic reload,
    input wire logic pd_watchdog_expired,
    input wire logic [5:0] cfg_in_words,
    input wire logic [5:0] cfg_out_words,
    input wire logic cfg_baud_fast,
    input wire logic [7:0] cfg_ring_id,
    input wire logic [7:0] fw_revision,
    input wire logic ecat_out_valid,
    output logic ecat_out_ready,
    input wire logic [15:0] ecat_out_data,
    output logic [15:0] ecat_in_data [MAX_WORDS],
    output logic [15:0] status_word,
    output logic [15:0] abort_code,
    output logic [1:0] gw_ecat_state,
    output logic ring_protocol_chip_reset,
    output logic station_error_flag_n,
    output logic baud_fast_active,
    input wire logic ring_data_in,
    input wire logic ring_cycle_start,
    input wire logic ring_id_cycle,
    input wire logic ring_frame_end,
    input wire logic ring_crc_ok,
    output logic ring_data_out,
    output logic ring_rx_valid
);
    //==========================================================
    // configuration checks and stored ring parameters
    //==========================================================
    gw_state_t state_reg;
    gw_state_t state_next;
    logic in_words_ok;
    logic out_words_ok;
    logic cfg_present;
    logic store_valid_reg;
    logic stored_baud_reg;
    logic [7:0] stored_id_reg;
    logic cfg_mismatch;
    logic baud_reg;
    logic [5:0] n_in_reg;
    logic [5:0] n_out_reg;
    logic [15:0] abort_reg;

    function automatic logic words_legal(input logic [5:0] n);
        words_legal = (n <= 6'(MAX_WORDS));
    endfunction : words_legal

    assign in_words_ok = words_legal(cfg_in_words);
    assign out_words_ok = words_legal(cfg_out_words);
    assign cfg_present = (n_in_reg != '0) || (n_out_reg != '0); // counts taken at reload
    // ring settings are kept by every revision; only firmware from revision 02 compares them
    assign cfg_mismatch = (fw_revision >= FW_REV_STORE) && store_valid_reg
        && ((stored_baud_reg != cfg_baud_fast) || (stored_id_reg != cfg_ring_id));

    //==========================================================
    // ethercat side state machine
    //==========================================================
    wire ecat_init = (ecat_state_t'(ecat_state) == ECAT_INIT);
    wire ecat_op_req = (ecat_state_t'(ecat_state) == ECAT_OP);

    // next state decision
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            GW_INIT: begin
                if (!ecat_init) state_next = GW_CHECK;
            end
            GW_CHECK: begin
                if (cfg_mismatch) state_next = GW_ABORT;
                else if (!in_words_ok || !out_words_ok) state_next = GW_ABORT;
                else state_next = GW_SAFEOP;
            end
            GW_SAFEOP: begin
                if (ecat_op_req && cfg_present) state_next = GW_OP;
            end
            GW_OP: begin
                if (!ecat_op_req) state_next = GW_SAFEOP;
            end
            GW_ABORT: begin
                state_next = GW_ABORT;
            end
            default: state_next = GW_INIT;
        endcase
        if (ecat_init || reload) state_next = GW_INIT;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) state_reg <= GW_INIT;
        else state_reg <= state_next;
    end

    // latch configuration on each reinitialisation that passes the checks
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            baud_reg <= BAUD_DEFAULT;
            n_in_reg <= '0;
            n_out_reg <= '0;
            abort_reg <= STAT_NONE;
            store_valid_reg <= 1'b0;
            stored_baud_reg <= BAUD_DEFAULT;
            stored_id_reg <= '0;
        end else if (state_reg == GW_CHECK) begin
            if (state_next == GW_SAFEOP) begin
                baud_reg <= cfg_baud_fast;
                n_in_reg <= cfg_in_words;
                n_out_reg <= cfg_out_words;
                abort_reg <= STAT_NONE;
                store_valid_reg <= 1'b1;
                stored_baud_reg <= cfg_baud_fast;
                stored_id_reg <= cfg_ring_id;
            end else if (state_next == GW_ABORT) begin
                abort_reg <= ABORT_CFG_MISMATCH;
            end
        end
    end

    assign abort_code = abort_reg;
    assign baud_fast_active = baud_reg;
    assign gw_ecat_state = (state_reg == GW_OP) ? ECAT_OP
        : (state_reg == GW_SAFEOP) ? ECAT_SAFEOP
        : (state_reg == GW_INIT) ? ECAT_INIT : ECAT_PREOP;
    assign ring_protocol_chip_reset = (state_reg == GW_INIT);

    //==========================================================
    // pin synchronisers: change counts when stages 2 and 3 agree
    //==========================================================
    logic [4:0] pin_s1_reg;
    logic [4:0] pin_s2_reg;
    logic [4:0] pin_s3_reg;
    logic [4:0] pin_reg;
    wire [4:0] pin_raw = {ring_crc_ok, ring_frame_end, ring_id_cycle,
        ring_cycle_start, ring_data_in};
    always_ff @(posedge clk_sys) begin
        pin_s1_reg <= pin_raw;
        pin_s2_reg <= pin_s1_reg;
        pin_s3_reg <= pin_s2_reg;
    end
    genvar gp;
    generate
        for (gp = 0; gp < 5; gp++) begin : g_pin
            always_ff @(posedge clk_sys) begin
                if (reset) pin_reg[gp] <= 1'b0;
                else if (pin_s2_reg[gp] == pin_s3_reg[gp]) pin_reg[gp] <= pin_s3_reg[gp];
            end
        end
    endgenerate
    logic [4:0] pin_d_reg;
    always_ff @(posedge clk_sys) begin
        if (reset) pin_d_reg <= '0;
        else pin_d_reg <= pin_reg;
    end
    wire rx_bit = pin_reg[0];
    wire start_rise = pin_reg[1] && !pin_d_reg[1];
    wire id_mode = pin_reg[2];
    wire end_rise = pin_reg[3] && !pin_d_reg[3];
    wire crc_ok = pin_reg[4];

    //==========================================================
    // station error flag and status word
    //==========================================================
    logic stat_err_reg;
    logic bad_data_reg;
    logic sent_any_reg;
    wire err_cond = (state_reg != GW_OP) || pd_watchdog_expired;
    always_ff @(posedge clk_sys) begin
        if (reset) stat_err_reg <= 1'b1;
        else stat_err_reg <= err_cond;
    end
    assign station_error_flag_n = !stat_err_reg;
    // status word codes
    always_ff @(posedge clk_sys) begin
        if (reset) status_word <= STAT_NONE;
        else if (stat_err_reg || !sent_any_reg) status_word <= STAT_NO_DATA;
        else if (bad_data_reg) status_word <= STAT_BAD_DATA;
        else status_word <= STAT_NONE;
    end

    //==========================================================
    // bit rate enable divider
    //==========================================================
    logic [DIV_W-1:0] div_reg;
    wire [DIV_W-1:0] div_top = baud_reg ? DIV_FAST_C : DIV_SLOW_C;
    wire bit_tick = (div_reg == '0);
    always_ff @(posedge clk_sys) begin
        if (reset || start_rise) div_reg <= div_top;
        else if (bit_tick) div_reg <= div_top;
        else div_reg <= DIV_W'(div_reg - 1'b1);
    end

    //==========================================================
    // ethercat output words through fifo to ring tx register
    //==========================================================
    word_stream_if fin();
    word_stream_if fout();
    assign fin.valid = ecat_out_valid;
    assign fin.data = ecat_out_data;
    assign ecat_out_ready = fin.ready;
    word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .reset(reset),
        .wr(fin),
        .rd(fout)
    );

    logic [15:0] tx_img_reg [MAX_WORDS];
    logic [IDX_W-1:0] load_idx_reg;
    wire load_fire = fout.valid && fout.ready;
    assign fout.ready = (n_out_reg != '0); // stalls until outputs configured
    // output image filled in order from the fifo
    always_ff @(posedge clk_sys) begin
        if (reset || state_reg == GW_INIT) begin
            load_idx_reg <= '0;
        end else if (load_fire) begin
            tx_img_reg[load_idx_reg] <= fout.data;
            if ({1'b0, load_idx_reg} == 6'(n_out_reg - 1'b1)) load_idx_reg <= '0;
            else load_idx_reg <= IDX_W'(load_idx_reg + 1'b1);
        end
    end

    //==========================================================
    // distributed shift register: send and receive together
    //==========================================================
    localparam int SH_W = MAX_WORDS * WORD_W;
    logic [SH_W-1:0] tx_sh_reg;
    logic [SH_W-1:0] rx_sh_reg;
    logic [15:0] id_word;
    logic [15:0] tx_flat [MAX_WORDS];
    assign id_word = {MODULE_TYPE, n_in_reg[3:0] , n_out_reg[2:0], stat_err_reg};
    genvar gw;
    generate
        for (gw = 0; gw < MAX_WORDS; gw++) begin : g_tx
            assign tx_flat[gw] = (gw < n_out_reg) ? tx_img_reg[gw] : STAT_NONE;
        end
    endgenerate
    function automatic logic [SH_W-1:0] pack_img(input logic [15:0] img [MAX_WORDS]);
        pack_img = '0;
        for (int i = 0; i < MAX_WORDS; i++) pack_img[SH_W-1-i*WORD_W -: WORD_W] = img[i];
    endfunction : pack_img
    // shift one bit per tick, msb of word 0 first
    always_ff @(posedge clk_sys) begin
        if (reset || ring_protocol_chip_reset) begin
            tx_sh_reg <= '0;
            rx_sh_reg <= '0;
            sent_any_reg <= 1'b0;
        end else if (start_rise) begin
            tx_sh_reg <= id_mode ? {id_word, {(SH_W-WORD_W){1'b0}}} : pack_img(tx_flat);
        end else if (bit_tick) begin
            tx_sh_reg <= {tx_sh_reg[SH_W-2:0], 1'b0};
            rx_sh_reg <= {rx_sh_reg[SH_W-2:0], rx_bit};
            sent_any_reg <= 1'b1;
        end
    end
    assign ring_data_out = tx_sh_reg[SH_W-1];

    // frame end: capture received words into ethercat inputs
    genvar gi;
    generate
        for (gi = 0; gi < MAX_WORDS; gi++) begin : g_rx
            always_ff @(posedge clk_sys) begin
                if (reset) ecat_in_data[gi] <= STAT_NONE;
                else if (end_rise && crc_ok && !id_mode && gi < n_in_reg)
                    ecat_in_data[gi] <= rx_sh_reg[(gi+1)*WORD_W-1 -: WORD_W];
            end
        end
    endgenerate
    // invalid ring data flag, set wins over clear
    always_ff @(posedge clk_sys) begin
        if (reset) bad_data_reg <= 1'b0;
        else if (end_rise && !crc_ok) bad_data_reg <= 1'b1;
        else if (end_rise) bad_data_reg <= 1'b0;
    end
    assign ring_rx_valid = !stat_err_reg;

    //==========================================================
    // assertions
    //==========================================================
    property p_init_reset;
        @(posedge clk_sys) disable iff (reset)
        ecat_init |=> ring_protocol_chip_reset;
    endproperty
    a_init_reset: assert property (p_init_reset) else $error("chip not reset in init");
    property p_noop_err;
        @(posedge clk_sys) disable iff (reset)
        (state_reg != GW_OP) |=> !station_error_flag_n && !ring_rx_valid;
    endproperty
    a_noop_err: assert property (p_noop_err) else $error("no station error outside op");
    property p_wd_err;
        @(posedge clk_sys) disable iff (reset)
        pd_watchdog_expired |=> !station_error_flag_n;
    endproperty
    a_wd_err: assert property (p_wd_err) else $error("watchdog did not flag error");
    property p_clear_ok;
        @(posedge clk_sys) disable iff (reset)
        $rose(station_error_flag_n) |-> $past(state_reg == GW_OP) && !$past(pd_watchdog_expired);
    endproperty
    a_clear_ok: assert property (p_clear_ok) else $error("error cleared wrongly");
    property p_no_words;
        @(posedge clk_sys) disable iff (reset)
        (n_in_reg == '0 && n_out_reg == '0 && state_reg == GW_SAFEOP) |=> state_reg != GW_OP;
    endproperty
    a_no_words: assert property (p_no_words) else $error("op without process words");
    property p_stat_code;
        @(posedge clk_sys) disable iff (reset)
        stat_err_reg |=> status_word == STAT_NO_DATA;
    endproperty
    a_stat_code: assert property (p_stat_code) else $error("status not 0x2000");
    property p_stat_zero;
        @(posedge clk_sys) disable iff (reset)
        (!stat_err_reg && sent_any_reg && !bad_data_reg) |=> status_word == STAT_NONE;
    endproperty
    a_stat_zero: assert property (p_stat_zero) else $error("status not zero");
    sequence s_mismatch;
        state_reg == GW_CHECK && cfg_mismatch;
    endsequence
    property p_abort;
        @(posedge clk_sys) disable iff (reset)
        s_mismatch |=> abort_code == ABORT_CFG_MISMATCH && state_reg == GW_ABORT;
    endproperty
    a_abort: assert property (p_abort) else $error("mismatch did not abort");
endmodule : ring_fieldbus_slave_gateway

// ---- design/ring_gw_pkg.sv ----
// package with constants and types for the ring fieldbus gateway
package ring_gw_pkg;
    localparam int WORD_W = 16;
    localparam int MAX_WORDS = 32;
    localparam int CNT_W = 6;
    localparam int IDX_W = 5;
    localparam int FIFO_DEPTH = 32;
    localparam logic [15:0] STAT_NONE = 16'h0000;
    localparam logic [15:0] STAT_NO_DATA = 16'h2000;
    localparam logic [15:0] STAT_BAD_DATA = 16'h4000;
    localparam logic [15:0] ABORT_CFG_MISMATCH = 16'h0026;
    localparam logic [7:0] FW_REV_STORE = 8'h02;
    localparam logic [7:0] MODULE_TYPE = 8'h03; // arbitrary value
    localparam logic BAUD_DEFAULT = 1'b1;
    // ring bit period at 100 MHz
    localparam int CLK_MHZ = 100;
    localparam int RATE_FAST_KBIT = 2000;
    localparam int RATE_SLOW_KBIT = 500;
    localparam int DIV_FAST = (CLK_MHZ * 1000) / RATE_FAST_KBIT;
    localparam int DIV_SLOW = (CLK_MHZ * 1000) / RATE_SLOW_KBIT;
    localparam int DIV_W = 8;
    localparam logic [DIV_W-1:0] DIV_FAST_C = DIV_W'(DIV_FAST - 1);
    localparam logic [DIV_W-1:0] DIV_SLOW_C = DIV_W'(DIV_SLOW - 1);
    typedef enum logic [1:0] {ECAT_INIT, ECAT_PREOP, ECAT_SAFEOP, ECAT_OP} ecat_state_t;
    typedef enum {GW_INIT, GW_CHECK, GW_SAFEOP, GW_OP, GW_ABORT} gw_state_t;
endpackage : ring_gw_pkg

// ---- design/word_stream_if.sv ----
// interface carrying a 16-bit word stream with valid and ready
`timescale 1ns/1ns
interface word_stream_if;
    logic valid;
    logic ready;
    logic [15:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface : word_stream_if

// ---- design/word_fifo.sv ----
// parameterised word fifo with valid and ready on both sides
`timescale 1ns/1ns
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic reset,
    word_stream_if.dst wr,
    word_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wptr_reg;
    logic [AW-1:0] rptr_reg;
    logic [AW:0] count_reg;
    wire push = wr.valid && wr.ready;
    wire pop = rd.valid && rd.ready;
    // honest full and empty
    assign wr.ready = (count_reg != (AW+1)'(DEPTH));
    assign rd.valid = (count_reg != '0);
    assign rd.data = mem_reg[rptr_reg];
    // storage write
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_reg[wptr_reg] <= wr.data;
        end
    end
    // pointers and fill count
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) wptr_reg <= AW'(wptr_reg + 1'b1);
            if (pop) rptr_reg <= AW'(rptr_reg + 1'b1);
            count_reg <= (AW+1)'(count_reg + push - pop);
        end
    end
endmodule : word_fifo

// ---- testbench/ring_master_model.sv ----
// behavioural ring fieldbus master that runs data cycles through the gateway
`timescale 1ns/1ns
module ring_master_model (
    input wire logic clk_sys,
    input wire logic ring_data_out,
    output logic ring_data_in,
    output logic ring_cycle_start,
    output logic ring_id_cycle,
    output logic ring_frame_end,
    output logic ring_crc_ok
);
    //==========================================================
    // idle levels
    //==========================================================
    initial begin
        ring_data_in = 1'b0;
        ring_cycle_start = 1'b0;
        ring_id_cycle = 1'b0;
        ring_frame_end = 1'b0;
        ring_crc_ok = 1'b0;
    end

    // one data cycle: send and receive at once through the shift chain
    task automatic run_frame(input int nbits, input int period, input logic [511:0] tx,
                             input logic crc, input logic id, output logic [511:0] rx);
        rx = '0;
        @(posedge clk_sys);
        ring_cycle_start <= 1'b1;
        ring_id_cycle <= id;
        repeat (4) @(posedge clk_sys);
        for (int k = 0; k < nbits; k++) begin
            ring_data_in <= tx[nbits-1-k];
            repeat (period / 2) @(posedge clk_sys);
            rx = {rx[510:0], ring_data_out};
            repeat (period - period / 2) @(posedge clk_sys);
        end
        // released line shows the inverse of its last bit
        ring_data_in <= ~tx[0];
        ring_cycle_start <= 1'b0;
        ring_crc_ok <= crc;
        ring_frame_end <= 1'b1;
        repeat (8) @(posedge clk_sys);
        ring_frame_end <= 1'b0;
        ring_crc_ok <= 1'b0;
        ring_id_cycle <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask : run_frame

    // acknowledge of the reset error: identification line raised for 8 cycles without a cycle start
    task automatic ack_error;
        @(posedge clk_sys);
        ring_id_cycle <= 1'b1;
        repeat (8) @(posedge clk_sys);
        ring_id_cycle <= 1'b0;
    endtask : ack_error
endmodule : ring_master_model

// ---- testbench/tb.sv ----
// self-checking bench for the ring fieldbus slave gateway
`timescale 1ns/1ns
module tb;
    import ring_gw_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [1:0] ecat_state = 2'h0;
    logic reload = 1'b0;
    logic pd_watchdog_expired = 1'b0;
    logic [5:0] cfg_in_words = 6'h00;
    logic [5:0] cfg_out_words = 6'h00;
    logic cfg_baud_fast = 1'b1;
    logic [7:0] cfg_ring_id = 8'h11;
    logic [7:0] fw_revision = 8'h02;
    logic ecat_out_valid = 1'b0;
    logic [15:0] ecat_out_data = 16'h0000;
    logic ecat_out_ready;
    logic [15:0] ecat_in_data [MAX_WORDS];
    logic [15:0] status_word;
    logic [15:0] abort_code;
    logic [1:0] gw_ecat_state;
    logic ring_protocol_chip_reset, station_error_flag_n, baud_fast_active;
    logic ring_data_in, ring_cycle_start, ring_id_cycle, ring_frame_end, ring_crc_ok;
    logic ring_data_out, ring_rx_valid;
    logic [511:0] rx;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;

    //==========================================================
    // design and ring master
    //==========================================================
    ring_fieldbus_slave_gateway dut (.clk_sys(clk_sys), .reset(reset),
        .ecat_state(ecat_state), .reload(reload), .pd_watchdog_expired(pd_watchdog_expired),
        .cfg_in_words(cfg_in_words), .cfg_out_words(cfg_out_words),
        .cfg_baud_fast(cfg_baud_fast), .cfg_ring_id(cfg_ring_id), .fw_revision(fw_revision),
        .ecat_out_valid(ecat_out_valid), .ecat_out_ready(ecat_out_ready),
        .ecat_out_data(ecat_out_data), .ecat_in_data(ecat_in_data),
        .status_word(status_word), .abort_code(abort_code), .gw_ecat_state(gw_ecat_state),
        .ring_protocol_chip_reset(ring_protocol_chip_reset),
        .station_error_flag_n(station_error_flag_n), .baud_fast_active(baud_fast_active),
        .ring_data_in(ring_data_in), .ring_cycle_start(ring_cycle_start),
        .ring_id_cycle(ring_id_cycle), .ring_frame_end(ring_frame_end),
        .ring_crc_ok(ring_crc_ok), .ring_data_out(ring_data_out),
        .ring_rx_valid(ring_rx_valid));
    ring_master_model m (.clk_sys(clk_sys), .ring_data_out(ring_data_out),
        .ring_data_in(ring_data_in), .ring_cycle_start(ring_cycle_start),
        .ring_id_cycle(ring_id_cycle), .ring_frame_end(ring_frame_end),
        .ring_crc_ok(ring_crc_ok));

    // clock and hang guard
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_errors++;
            test_done();
        end
    end

    //==========================================================
    // shared tasks
    //==========================================================
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic push(input logic [15:0] w, output logic ok);
        @(posedge clk_sys);
        ecat_out_valid <= 1'b1;
        ecat_out_data <= w;
        #1;
        ok = ecat_out_ready;
        @(posedge clk_sys);
        ecat_out_valid <= 1'b0;
    endtask : push
    task automatic bring_up(input logic [5:0] n_in, input logic [5:0] n_out);
        @(posedge clk_sys);
        cfg_in_words <= n_in;
        cfg_out_words <= n_out;
        reload <= 1'b1;
        ecat_state <= 2'(ECAT_INIT);
        tick(4);
        chk("chip reset", 16'h0001, 16'(ring_protocol_chip_reset));
        @(posedge clk_sys);
        reload <= 1'b0;
        ecat_state <= 2'(ECAT_OP);
        tick(10);
        m.ack_error();
        tick(1);
    endtask : bring_up

    //==========================================================
    // scenarios
    //==========================================================
    task automatic t_reset;
        chk("state", 16'(ECAT_INIT), 16'(gw_ecat_state));
        chk("chip reset", 16'h0001, 16'(ring_protocol_chip_reset));
        chk("flag", 16'h0000, 16'(station_error_flag_n));
        chk("status", STAT_NO_DATA, status_word);
        chk("abort", 16'h0000, abort_code);
        chk("baud", 16'(BAUD_DEFAULT), 16'(baud_fast_active));
    endtask : t_reset
    task automatic t_no_words;
        logic ok;
        int n;
        n = 0;
        @(posedge clk_sys);
        ecat_state <= 2'(ECAT_OP);
        tick(20);
        chk("state", 16'(ECAT_SAFEOP), 16'(gw_ecat_state));
        chk("flag", 16'h0000, 16'(station_error_flag_n));
        chk("rx valid", 16'h0000, 16'(ring_rx_valid));
        chk("status", STAT_NO_DATA, status_word);
        for (int i = 0; i < FIFO_DEPTH + 1; i++) begin
            push(16'(i), ok);
            n += int'(ok);
        end
        chk("accepted", 16'(FIFO_DEPTH), 16'(n));
    endtask : t_no_words
    task automatic t_op;
        bring_up(6'h02, 6'h02);
        chk("ready", 16'h0001, 16'(ecat_out_ready));
        chk("state", 16'(ECAT_OP), 16'(gw_ecat_state));
        chk("chip reset", 16'h0000, 16'(ring_protocol_chip_reset));
        chk("flag", 16'h0001, 16'(station_error_flag_n));
        chk("rx valid", 16'h0001, 16'(ring_rx_valid));
        @(posedge clk_sys);
        pd_watchdog_expired <= 1'b1;
        tick(3);
        chk("flag", 16'h0000, 16'(station_error_flag_n));
        @(posedge clk_sys);
        pd_watchdog_expired <= 1'b0;
        tick(3);
        chk("flag", 16'h0001, 16'(station_error_flag_n));
    endtask : t_op
    task automatic t_frame(input int period);
        logic ok;
        push(16'hA5C3, ok);
        push(16'h0F1E, ok);
        tick(4);
        m.run_frame(32, period, 512'h1234_5678, 1'b1, 1'b0, rx);
        tick(2);
        chk("ring word 0", 16'hA5C3, rx[31:16]);
        chk("ring word 1", 16'h0F1E, rx[15:0]);
        chk("in word 0", 16'h5678, ecat_in_data[0]);
        chk("in word 1", 16'h1234, ecat_in_data[1]);
        chk("status", STAT_NONE, status_word);
    endtask : t_frame
    task automatic t_bad_crc;
        m.run_frame(32, DIV_FAST, 512'h0BAD_F00D, 1'b0, 1'b0, rx);
        tick(2);
        chk("status", STAT_BAD_DATA, status_word);
    endtask : t_bad_crc
    // identification cycle: id word out, inputs left untouched
    task automatic t_id;
        m.run_frame(16, DIV_FAST, '0, 1'b1, 1'b1, rx);
        tick(2);
        chk("id word", {MODULE_TYPE, 4'h2, 3'h2, 1'b0}, rx[15:0]);
        chk("in word 0", 16'h5678, ecat_in_data[0]);
    endtask : t_id
    task automatic t_abort;
        @(posedge clk_sys);
        cfg_ring_id <= 8'h22;
        bring_up(6'h02, 6'h02);
        chk("abort", ABORT_CFG_MISMATCH, abort_code);
        chk("state", 16'(ECAT_PREOP), 16'(gw_ecat_state));
    endtask : t_abort
    task automatic t_slow;
        @(posedge clk_sys);
        fw_revision <= 8'h01;
        cfg_baud_fast <= 1'b0;
        bring_up(6'h02, 6'h02);
        chk("abort", 16'h0000, abort_code);
        chk("baud", 16'h0000, 16'(baud_fast_active));
        t_frame(DIV_SLOW);
    endtask : t_slow

    task automatic test_done;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    // main sequence
    initial begin
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        tick(1);
        t_reset();
        t_no_words();
        t_op();
        t_frame(DIV_FAST);
        t_id();
        t_bad_crc();
        t_frame(DIV_FAST);
        t_abort();
        t_slow();
        test_done();
    end
endmodule : tb
